// ### pkg/amcc_pkg.sv
`default_nettype none

package amcc_pkg;

    // Frame geometry
    localparam int unsigned AMCC_CMD_BITS   = 16;
    localparam int unsigned AMCC_NUM_CH     = 9;
    localparam logic [5:0]  AMCC_CMD_LAST   = 6'h0f;
    localparam logic [5:0]  AMCC_BIT_MAX    = 6'h3f;

    // Command words
    localparam logic [15:0] AMCC_CMD_CONT   = 16'h0000;
    localparam logic [15:0] AMCC_CMD_LIGHT  = 16'h8200;
    localparam logic [15:0] AMCC_CMD_DEEP   = 16'h8300;
    localparam logic [15:0] AMCC_CMD_DEFLT  = 16'h8500;
    localparam logic [15:0] AMCC_CMD_AUTO   = 16'ha000;
    localparam logic [15:0] AMCC_CMD_AUX    = 16'he000;
    localparam logic [3:0]  AMCC_MAN_LO_NIB = 4'hc;
    localparam logic [3:0]  AMCC_MAN_HI_NIB = 4'hd;
    localparam logic [3:0]  AMCC_AUX_CHAN   = 4'h8;

    // Config register window reached by access words
    localparam logic [6:0]  AMCC_CFG_FIRST  = 7'h01;
    localparam logic [6:0]  AMCC_CFG_LAST   = 7'h3c;
    localparam int unsigned AMCC_WR_BIT     = 8;

    // Timing
    localparam int unsigned AMCC_CLK_NS        = 10;
    localparam int unsigned AMCC_LIGHT_WAKE_US = 20;
    localparam int unsigned AMCC_DEEP_WAKE_MS  = 15;
    localparam int unsigned AMCC_LIGHT_WAKE_CYC = (AMCC_LIGHT_WAKE_US * 1000 + AMCC_CLK_NS - 1) / AMCC_CLK_NS;
    localparam int unsigned AMCC_DEEP_WAKE_CYC  = (AMCC_DEEP_WAKE_MS * 1000000 + AMCC_CLK_NS - 1) / AMCC_CLK_NS;
    localparam int unsigned AMCC_WAKE_W         = 21;

    // Reset values
    localparam logic [15:0] AMCC_RST_WORD   = 16'h0000;
    localparam logic [3:0]  AMCC_RST_CHAN   = 4'h0;

    typedef enum logic [2:0] {
        AMCC_IDLE  = 3'b000,
        AMCC_AUTO  = 3'b001,
        AMCC_MAN   = 3'b011,
        AMCC_LIGHT = 3'b010,
        AMCC_DEEP  = 3'b110,
        AMCC_DEFLT = 3'b111
    } amcc_mode_e;

    typedef logic [AMCC_NUM_CH-1:0][3:0] amcc_range_t;

    typedef struct packed {
        logic       stb;
        logic [3:0] chan;
        logic [3:0] range;
    } amcc_sample_s;

    typedef struct packed {
        logic       stb;
        logic [6:0] addr;
        logic [7:0] data;
    } amcc_cfg_wr_s;

endpackage

`default_nettype wire

// ### src/amcc_mode_ctrl.sv
// Overview of operation
// - All-zero command keeps last selected mode
// - Continuing leaves config registers untouched
// - Frame starts at select fall; 16 bits in
// - Act only after 16th clock falling edge
// - Early select rise aborts frame to idle
// - Idle answers all ones on data out
// - Aborted config access is discarded
// - Light sleep on 8200h at frame end
// - Light sleep exit by conversion keeps config, 20us
// - Sleep persists until conversion, 8500h or short frame
// - Sleep: config access works, tail ones
// - Wake at frame end, sample next fall
// - Deep sleep on 8300h, all powered off
// - Deep sleep exit keeps config contents
// - A000h scans enabled channels ascending, wraps
// - Scan set comes from scan mask
// - Repeated A000h restarts at lowest channel
// - Fixed channel sampled at next frame start
// - Fixed channel repeats until new command
// - Each channel uses its own range
// - Channel words C000h..DC00h, E000h auxiliary
// - Data out released at frame end
// - Result MSB out at 16th falling edge
`timescale 1ns/100ps
`default_nettype none

module amcc_mode_ctrl #(
    parameter int unsigned DEEP_WAKE_CYC = amcc_pkg::AMCC_DEEP_WAKE_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic                  cs_n_pin,
    input  wire logic                  sclk_pin,
    input  wire logic                  sdi_pin,
    output var  logic                  sdo_o,
    output var  logic                  sdo_oe,
    input  wire logic [7:0]            scan_mask,
    input  wire amcc_pkg::amcc_range_t chan_range,
    input  wire logic [15:0]           conv_data,
    output var  amcc_pkg::amcc_sample_s sample,
    output var  amcc_pkg::amcc_cfg_wr_s cfg_wr,
    output var  logic                  cfg_defaults,
    output var  amcc_pkg::amcc_mode_e  mode_o,
    output var  logic [3:0]            chan_o,
    output var  logic                  ref_on,
    output var  logic                  core_on,
    output var  logic                  pwr_ready
);
    import amcc_pkg::*;

    typedef struct packed {
        logic [2:0]                cs_sync;
        logic [2:0]                sclk_sync;
        logic [2:0]                sdi_sync;
        logic                      cs_f;
        logic                      sclk_f;
        logic                      sdi_f;
        logic                      in_frame;
        logic                      frame_conv;
        logic [5:0]                bitcnt;
        logic [15:0]               cmd;
        logic [15:0]               shreg;
        logic                      sdo;
        logic                      sdo_oe;
        amcc_mode_e                mode;
        logic [3:0]                chan;
        logic [AMCC_WAKE_W-1:0]    wake_cnt;
        logic                      ref_on;
        logic                      core_on;
        logic                      pwr_ready;
        amcc_sample_s              sample;
        amcc_cfg_wr_s              cfg_wr;
        logic                      cfg_defaults;
    } amcc_state_s;

    amcc_state_s st_ff;
    amcc_state_s nxt_st;

    localparam logic [AMCC_WAKE_W-1:0] LIGHT_WAKE = AMCC_WAKE_W'(AMCC_LIGHT_WAKE_CYC);
    localparam logic [AMCC_WAKE_W-1:0] DEEP_WAKE  = AMCC_WAKE_W'(DEEP_WAKE_CYC);

    // Lowest enabled channel
    function automatic logic [3:0] scan_first(input logic [7:0] mask);
        logic [3:0] r;
        r = AMCC_RST_CHAN;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Next enabled channel above cur, wrapping to the lowest
    function automatic logic [3:0] scan_next(input logic [3:0] cur, input logic [7:0] mask);
        logic [3:0] r;
        r = scan_first(mask);
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && (4'(i) > cur)) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic is_fixed_word(input logic [15:0] w);
        return ((w[15:12] == AMCC_MAN_LO_NIB) || (w[15:12] == AMCC_MAN_HI_NIB)) && (w[9:0] == 10'h000);
    endfunction

    function automatic logic is_sleep(input amcc_mode_e m);
        return (m == AMCC_LIGHT) || (m == AMCC_DEEP);
    endfunction

    logic cs_agree;
    logic sclk_agree;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic [15:0] first_word;
    logic        fill_bit;
    logic [3:0]  new_chan;
    logic        go_conv;

    always_comb begin
        nxt_st = st_ff;
        first_word = AMCC_RST_WORD;
        fill_bit = 1'b0;
        new_chan = st_ff.chan;
        go_conv = 1'b0;

        nxt_st.sample.stb = 1'b0;
        nxt_st.cfg_wr.stb = 1'b0;
        nxt_st.cfg_defaults = 1'b0;

        // Pin synchronisers; a change counts once stages two and three agree
        nxt_st.cs_sync   = {st_ff.cs_sync[1:0], cs_n_pin};
        nxt_st.sclk_sync = {st_ff.sclk_sync[1:0], sclk_pin};
        nxt_st.sdi_sync  = {st_ff.sdi_sync[1:0], sdi_pin};
        cs_agree   = st_ff.cs_sync[1] == st_ff.cs_sync[2];
        sclk_agree = st_ff.sclk_sync[1] == st_ff.sclk_sync[2];
        if (cs_agree) begin
            nxt_st.cs_f = st_ff.cs_sync[2];
        end
        if (sclk_agree) begin
            nxt_st.sclk_f = st_ff.sclk_sync[2];
        end
        if (st_ff.sdi_sync[1] == st_ff.sdi_sync[2]) begin
            nxt_st.sdi_f = st_ff.sdi_sync[2];
        end
        cs_fall   = cs_agree && st_ff.cs_f && !st_ff.cs_sync[2];
        cs_rise   = cs_agree && !st_ff.cs_f && st_ff.cs_sync[2];
        sclk_fall = sclk_agree && st_ff.sclk_f && !st_ff.sclk_sync[2];

        // Wake-up timer after leaving a sleep mode
        if (st_ff.wake_cnt != '0) begin
            nxt_st.wake_cnt = st_ff.wake_cnt - AMCC_WAKE_W'(1);
        end
        nxt_st.pwr_ready = st_ff.core_on && (st_ff.wake_cnt == '0);

        // Tail of non-converting frames reads ones, converting frames zeros
        fill_bit = !st_ff.frame_conv;
        first_word = st_ff.frame_conv ? conv_data : 16'hffff;

        if (cs_fall) begin
            nxt_st.in_frame = 1'b1;
            nxt_st.bitcnt = 6'h00;
            nxt_st.cmd = AMCC_RST_WORD;
            nxt_st.sdo_oe = 1'b1;
            nxt_st.sdo = (st_ff.mode == AMCC_IDLE);
            nxt_st.frame_conv = (st_ff.mode == AMCC_AUTO) || (st_ff.mode == AMCC_MAN);
            if ((st_ff.mode == AMCC_AUTO) || (st_ff.mode == AMCC_MAN)) begin
                nxt_st.sample.stb = 1'b1;
                nxt_st.sample.chan = st_ff.chan;
                nxt_st.sample.range = chan_range[st_ff.chan];
            end
        end else if (st_ff.in_frame && cs_rise) begin
            nxt_st.in_frame = 1'b0;
            nxt_st.sdo_oe = 1'b0;
            nxt_st.sdo = 1'b0;
            if (st_ff.bitcnt < 6'(AMCC_CMD_BITS)) begin
                // Short frame: drop the word and any config access
                nxt_st.mode = AMCC_IDLE;
            end else begin
                // Command executes only now, after the whole word is in
                if ((st_ff.mode == AMCC_AUTO) && st_ff.frame_conv) begin
                    new_chan = scan_next(st_ff.chan, scan_mask);
                end
                if (st_ff.cmd == AMCC_CMD_CONT) begin
                    nxt_st.mode = st_ff.mode;
                end else if (st_ff.cmd == AMCC_CMD_LIGHT) begin
                    nxt_st.mode = AMCC_LIGHT;
                end else if (st_ff.cmd == AMCC_CMD_DEEP) begin
                    nxt_st.mode = AMCC_DEEP;
                end else if (st_ff.cmd == AMCC_CMD_DEFLT) begin
                    nxt_st.mode = AMCC_DEFLT;
                    nxt_st.cfg_defaults = 1'b1;
                end else if (st_ff.cmd == AMCC_CMD_AUTO) begin
                    nxt_st.mode = AMCC_AUTO;
                    new_chan = scan_first(scan_mask);
                    go_conv = 1'b1;
                end else if (is_fixed_word(st_ff.cmd)) begin
                    nxt_st.mode = AMCC_MAN;
                    new_chan = {1'b0, st_ff.cmd[12:10]};
                    go_conv = 1'b1;
                end else if (st_ff.cmd == AMCC_CMD_AUX) begin
                    nxt_st.mode = AMCC_MAN;
                    new_chan = AMCC_AUX_CHAN;
                    go_conv = 1'b1;
                end else if (!st_ff.cmd[15]) begin
                    // Config access, taken in any mode
                    nxt_st.cfg_wr.stb = st_ff.cmd[AMCC_WR_BIT];
                    nxt_st.cfg_wr.addr = st_ff.cmd[15:9];
                    nxt_st.cfg_wr.data = st_ff.cmd[7:0];
                end
                nxt_st.chan = new_chan;
                if (go_conv && (st_ff.mode == AMCC_LIGHT)) begin
                    nxt_st.wake_cnt = LIGHT_WAKE;
                    nxt_st.pwr_ready = 1'b0;
                end else if (go_conv && (st_ff.mode == AMCC_DEEP)) begin
                    nxt_st.wake_cnt = DEEP_WAKE;
                    nxt_st.pwr_ready = 1'b0;
                end
            end
        end else if (st_ff.in_frame && sclk_fall) begin
            if (st_ff.bitcnt < 6'(AMCC_CMD_BITS)) begin
                nxt_st.cmd = {st_ff.cmd[14:0], st_ff.sdi_f};
            end
            if (st_ff.bitcnt != AMCC_BIT_MAX) begin
                nxt_st.bitcnt = st_ff.bitcnt + 6'h01;
            end
            if (st_ff.bitcnt == AMCC_CMD_LAST) begin
                nxt_st.sdo = first_word[15];
                nxt_st.shreg = {first_word[14:0], fill_bit};
            end else if (st_ff.bitcnt > AMCC_CMD_LAST) begin
                nxt_st.sdo = st_ff.shreg[15];
                nxt_st.shreg = {st_ff.shreg[14:0], fill_bit};
            end
        end

        // Power switches follow the mode
        nxt_st.core_on = !is_sleep(nxt_st.mode);
        nxt_st.ref_on = (nxt_st.mode != AMCC_DEEP);
        if (is_sleep(nxt_st.mode)) begin
            nxt_st.wake_cnt = '0;
            nxt_st.pwr_ready = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{
                cs_sync:      3'h7,
                sclk_sync:    3'h0,
                sdi_sync:     3'h0,
                cs_f:         1'b1,
                sclk_f:       1'b0,
                sdi_f:        1'b0,
                in_frame:     1'b0,
                frame_conv:   1'b0,
                bitcnt:       6'h00,
                cmd:          AMCC_RST_WORD,
                shreg:        16'h0000,
                sdo:          1'b0,
                sdo_oe:       1'b0,
                mode:         AMCC_IDLE,
                chan:         AMCC_RST_CHAN,
                wake_cnt:     '0,
                ref_on:       1'b1,
                core_on:      1'b1,
                pwr_ready:    1'b0,
                sample:       '0,
                cfg_wr:       '0,
                cfg_defaults: 1'b0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sdo_o        = st_ff.sdo;
    assign sdo_oe       = st_ff.sdo_oe;
    assign sample       = st_ff.sample;
    assign cfg_wr       = st_ff.cfg_wr;
    assign cfg_defaults = st_ff.cfg_defaults;
    assign mode_o       = st_ff.mode;
    assign chan_o       = st_ff.chan;
    assign ref_on       = st_ff.ref_on;
    assign core_on      = st_ff.core_on;
    assign pwr_ready    = st_ff.pwr_ready;

endmodule

`default_nettype wire

// ### sim/amcc_mode_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none

module amcc_mode_ctrl_checker
    import amcc_pkg::*;
#(
    parameter int unsigned DEEP_WAKE_CYC = 50
) (
    input wire logic                   mclk,
    input wire logic                   nrst,
    input wire logic                   cs_n_pin,
    input wire logic                   sdo_o,
    input wire logic                   sdo_oe,
    input wire amcc_pkg::amcc_range_t  chan_range,
    input wire amcc_pkg::amcc_sample_s sample,
    input wire amcc_pkg::amcc_cfg_wr_s cfg_wr,
    input wire logic                   cfg_defaults,
    input wire amcc_pkg::amcc_mode_e   mode_o,
    input wire logic [3:0]             chan_o,
    input wire logic                   ref_on,
    input wire logic                   core_on,
    input wire logic                   pwr_ready
);
    localparam int unsigned WAKE_MAX = (DEEP_WAKE_CYC > 2000 ? DEEP_WAKE_CYC : 2000) + 16;
    logic [21:0] wake_cnt_ff;

    // Cycles spent powered but not yet ready
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wake_cnt_ff <= '0;
        end else if (core_on && !pwr_ready) begin
            wake_cnt_ff <= wake_cnt_ff + 22'h1;
        end else begin
            wake_cnt_ff <= '0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_mode_at_end: assert property ($changed(mode_o) || $changed(chan_o) |-> $past(cs_n_pin, 1) && $past(cs_n_pin, 3))
        else $error("mode or channel changed inside a frame");
    a_deep_power: assert property (mode_o == AMCC_DEEP |-> !ref_on && !core_on)
        else $error("power left on in deep sleep");
    a_light_power: assert property (mode_o == AMCC_LIGHT |-> ref_on && !core_on)
        else $error("wrong power state in light sleep");
    a_wake_bound: assert property (core_on && !pwr_ready |-> {10'h0, wake_cnt_ff} < WAKE_MAX)
        else $error("wake-up took too long");
    a_wake_delay: assert property ($rose(core_on) |-> !pwr_ready [*8])
        else $error("ready without wake-up time");
    a_release_end: assert property (cs_n_pin [*5] |-> !sdo_oe)
        else $error("data out still driven after frame");
    a_idle_ones: assert property (sdo_oe && mode_o == AMCC_IDLE |-> sdo_o)
        else $error("idle answer not ones");
    a_sample_start: assert property (sample.stb |-> !$past(cs_n_pin, 1) && !$past(cs_n_pin, 3) && sample.chan == chan_o)
        else $error("sample not at frame start");
    a_sample_range: assert property (sample.stb |-> sample.range == chan_range[sample.chan])
        else $error("sample range mismatch");
    a_cfg_at_end: assert property (cfg_wr.stb || cfg_defaults |-> $past(cs_n_pin, 1) && $past(cs_n_pin, 3))
        else $error("config write inside a frame");
endmodule

bind amcc_mode_ctrl amcc_mode_ctrl_checker #(.DEEP_WAKE_CYC(DEEP_WAKE_CYC)) i_amcc_mode_ctrl_checker (
    .mclk(mclk), .nrst(nrst), .cs_n_pin(cs_n_pin), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .chan_range(chan_range),
    .sample(sample), .cfg_wr(cfg_wr), .cfg_defaults(cfg_defaults), .mode_o(mode_o), .chan_o(chan_o),
    .ref_on(ref_on), .core_on(core_on), .pwr_ready(pwr_ready));

`default_nettype wire

// ### sim/amcc_host.sv
`timescale 1ns/100ps
`default_nettype none

module amcc_host (
    input  wire logic mclk,
    input  wire logic sdo,
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic sdi
);
    logic [31:0] rx;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
        rx   = '0;
    end

    // Reply bit taken just before each falling edge
    task automatic frame(input logic [15:0] w, input int n);
        @(posedge mclk);
        cs_n <= 1'b0;
        repeat (8) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b1;
            sdi  <= (i < 16) ? w[15 - i] : 1'b0;
            repeat (4) @(posedge mclk);
            rx = {rx[30:0], sdo};
            sclk <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        cs_n <= 1'b1;
        sdi  <= ~sdi;
        repeat (8) @(posedge mclk);
    endtask
endmodule

`default_nettype wire

// ### sim/test_adc_mode_command_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_adc_mode_command_control;
    import amcc_pkg::*;
    typedef struct packed {
        logic [15:0] w;
        logic [31:0] rx;
        amcc_mode_e  md;
        logic [3:0]  ch;
    } amcc_row_s;
    localparam logic [15:0] CONV = 16'hc3a5;
    localparam logic [31:0] CV   = {16'h0000, CONV};
    localparam logic [31:0] NC   = 32'h0000ffff;
    localparam logic [31:0] ID   = 32'hffffffff;
    logic         mclk, nrst, sdo_o, sdo_oe, cfg_defaults, ref_on, core_on, pwr_ready;
    logic [3:0]   chan_o;
    logic [7:0]   scan_mask;
    wire logic    cs_n, sclk, sdi, sdo_w;
    amcc_sample_s sample;
    amcc_cfg_wr_s cfg_wr, last_wr;
    amcc_mode_e   mode_o;
    int           err_count, cmp_count, wr_count, def_count;
    amcc_row_s    rows [13] = '{
        '{16'ha000, ID, AMCC_AUTO, 4'h2}, '{16'h0000, CV, AMCC_AUTO, 4'h5}, '{16'h0000, CV, AMCC_AUTO, 4'h2},
        '{16'ha000, CV, AMCC_AUTO, 4'h2}, '{16'h0000, CV, AMCC_AUTO, 4'h5}, '{16'h8200, CV, AMCC_LIGHT, 4'h2},
        '{16'h0000, NC, AMCC_LIGHT, 4'h2}, '{16'h0b5a, NC, AMCC_LIGHT, 4'h2}, '{16'hc400, NC, AMCC_MAN, 4'h1},
        '{16'h8300, CV, AMCC_DEEP, 4'h1}, '{16'h0000, NC, AMCC_DEEP, 4'h1}, '{16'ha000, NC, AMCC_AUTO, 4'h2},
        '{16'h0000, CV, AMCC_AUTO, 4'h5}};

    assign sdo_w = sdo_oe ? sdo_o : 1'bz;

    amcc_mode_ctrl #(.DEEP_WAKE_CYC(50)) i_amcc_mode_ctrl (.mclk(mclk), .nrst(nrst), .cs_n_pin(cs_n),
        .sclk_pin(sclk), .sdi_pin(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .scan_mask(scan_mask),
        .chan_range(36'h876543210), .conv_data(CONV), .sample(sample), .cfg_wr(cfg_wr),
        .cfg_defaults(cfg_defaults), .mode_o(mode_o), .chan_o(chan_o), .ref_on(ref_on),
        .core_on(core_on), .pwr_ready(pwr_ready));
    amcc_host i_amcc_host (.mclk(mclk), .sdo(sdo_w), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Counts one-cycle pulses from the design
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_count  <= 0;
            def_count <= 0;
            last_wr   <= '0;
        end else begin
            if (cfg_wr.stb === 1'b1) begin
                wr_count <= wr_count + 1;
                last_wr  <= cfg_wr;
            end
            if (cfg_defaults === 1'b1) begin
                def_count <= def_count + 1;
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("Mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Wait out wake-up while powered
    task automatic settle;
        int n;
        n = 0;
        while (core_on === 1'b1 && pwr_ready !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        if (n == 3000) begin
            err_count++;
            test_done();
        end
        repeat (4) @(posedge mclk);
    endtask

    task automatic run(input logic [15:0] w, input logic [31:0] rx, input amcc_mode_e md, input logic [3:0] ch);
        i_amcc_host.frame(w, 32);
        chk(i_amcc_host.rx, rx);
        chk(32'(mode_o), 32'(md));
        chk({28'h0, chan_o}, {28'h0, ch});
        chk({31'h0, sdo_w}, {31'h0, 1'bz});
        settle();
    endtask

    initial begin
        nrst      = 1'b0;
        err_count = 0;
        cmp_count = 0;
        scan_mask <= 8'h24;
        repeat (16) @(posedge mclk);
        chk({25'h0, mode_o, chan_o}, {25'h0, AMCC_IDLE, 4'h0});
        chk({30'h0, ref_on, sdo_oe}, 32'h2);
        nrst <= 1'b1;
        settle();
        foreach (rows[i]) run(rows[i].w, rows[i].rx, rows[i].md, rows[i].ch);
        chk(wr_count, 1);
        chk({17'h0, last_wr.addr, last_wr.data}, {17'h0, 7'h05, 8'h5a});
        for (int c = 0; c < 9; c++) begin
            run(c < 8 ? 16'hc000 + 16'(c) * 16'h0400 : 16'he000, CV, AMCC_MAN, 4'(c));
        end
        run(16'h0000, CV, AMCC_MAN, 4'h8);
        i_amcc_host.frame(16'h0b5a, 15);
        chk(32'(mode_o), 32'(AMCC_IDLE));
        chk(wr_count, 1);
        i_amcc_host.frame(16'h0000, 32);
        chk(i_amcc_host.rx, ID);
        chk(32'(mode_o), 32'(AMCC_IDLE));
        scan_mask <= 8'h81;
        run(16'ha000, ID, AMCC_AUTO, 4'h0);
        run(16'h0000, CV, AMCC_AUTO, 4'h7);
        run(16'h0000, CV, AMCC_AUTO, 4'h0);
        run(16'h8500, CV, AMCC_DEFLT, 4'h7);
        run(16'h0000, NC, AMCC_DEFLT, 4'h7);
        chk(def_count, 1);
        // Reset in mid-run
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({25'h0, mode_o, chan_o}, {25'h0, AMCC_IDLE, 4'h0});
        nrst <= 1'b1;
        settle();
        run(16'h0000, ID, AMCC_IDLE, 4'h0);
        test_done();
    end
endmodule

`default_nettype wire
